// [rtl/fbl_pkg.sv]
// Purpose: Shared constants and types for the flash block-lock host controller
// Assumes: 25 MHz clk; x16 flash, commands on the low data byte
// Notes:   APB register map, flash command codes and pin timing live here
package fbl_pkg;

  localparam int CLK_NS      = 40;
  localparam int T_WP_NS     = 70;
  localparam int T_ACC_NS    = 70;
  localparam int SYNC_STAGES = 2;
  // Least times round up to whole cycles
  localparam logic [3:0] WP_CYC  = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  // One spare cycle so the synchronised data is past the access time
  localparam logic [3:0] RD_CYC  = 4'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES + 1);
  localparam logic [3:0] CNT_ONE = 4'h1;

  localparam logic [7:0] CMD_CFG_SETUP   = 8'h60;
  localparam logic [7:0] CMD_LOCK        = 8'h01;
  localparam logic [7:0] CMD_UNLOCK      = 8'hD0;
  localparam logic [7:0] CMD_LOCKDOWN    = 8'h2F;
  localparam logic [7:0] CMD_CFG_READ    = 8'h90;
  localparam logic [7:0] CMD_SUSPEND     = 8'hB0;
  localparam logic [7:0] CMD_RESUME      = 8'hD0;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;
  localparam int         LOCK_STATUS_OFS = 2;

  localparam int         APB_AW     = 8;
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_PINCTL = 8'h0C;

  localparam int   ST_BUSY_BIT    = 0;
  localparam int   ST_REFUSED_BIT = 1;
  localparam int   ST_DATA_LSB    = 16;
  localparam int   PIN_WP_BIT     = 0;
  localparam int   PIN_RST_BIT    = 1;
  localparam logic PIN_WP_RST     = 1'b0;
  localparam logic PIN_RST_RST    = 1'b1;

  typedef enum logic [2:0] {
    OP_NONE        = 3'b000,
    OP_LOCK        = 3'b001,
    OP_UNLOCK      = 3'b010,
    OP_LOCKDOWN    = 3'b011,
    OP_READ_LOCK   = 3'b100,
    OP_SUSPEND     = 3'b101,
    OP_RESUME      = 3'b110,
    OP_READ_STATUS = 3'b111
  } fbl_op_e;

  typedef struct packed {
    logic       last;
    logic       wr;
    logic       use_ofs;
    logic [7:0] code;
  } fbl_step_s;

  // One bus cycle of a host sequence, chosen by operation and step number
  function automatic fbl_step_s fbl_step(fbl_op_e op, logic [1:0] step);
    fbl_step_s s;
    s = '{last: 1'b1, wr: 1'b1, use_ofs: 1'b0, code: CMD_READ_ARRAY};
    case (op)
      OP_LOCK:        s.code = (step == 2'h0) ? CMD_CFG_SETUP : CMD_LOCK;
      OP_UNLOCK:      s.code = (step == 2'h0) ? CMD_CFG_SETUP : CMD_UNLOCK;
      OP_LOCKDOWN:    s.code = (step == 2'h0) ? CMD_CFG_SETUP : CMD_LOCKDOWN;
      OP_READ_STATUS: s.code = CMD_READ_STATUS;
      OP_SUSPEND:     s.code = CMD_SUSPEND;
      OP_RESUME:      s.code = CMD_RESUME;
      OP_READ_LOCK: begin
        if (step == 2'h0) begin
          s.code = CMD_CFG_READ;
        end else if (step == 2'h1) begin
          s.wr      = 1'b0;
          s.use_ofs = 1'b1;
        end
      end
      default: s.code = CMD_READ_ARRAY;
    endcase
    case (op)
      OP_LOCK, OP_UNLOCK, OP_LOCKDOWN, OP_READ_STATUS: begin
        s.last = (step == 2'h1);
        if (op == OP_READ_STATUS && step == 2'h1) begin
          s.wr = 1'b0;
        end
      end
      OP_READ_LOCK: s.last = (step == 2'h2);
      default:      s.last = 1'b1;
    endcase
    return s;
  endfunction

endpackage

// [rtl/fbl_cyc_if.sv]
// Purpose: One flash bus cycle request between sequencer and pin engine
// Assumes: req is a one-cycle pulse, only while the engine is idle
// Notes:   done pulses one cycle; rdata is valid with done of a read
`timescale 1ns/1ps
interface fbl_cyc_if #(parameter int ADDR_W = 22);
  logic              req;
  logic              wr;
  logic [ADDR_W-1:0] addr;
  logic [15:0]       wdata;
  logic              done;
  logic [15:0]       rdata;
  modport ctl (output req, output wr, output addr, output wdata, input done, input rdata);
  modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

// [rtl/fbl_cycle.sv]
// Purpose: Drives one asynchronous flash write or read cycle on the pins
// Assumes: Data input comes from the pad, so it is synchronised first
// Notes:   Setup, strobe and hold phases; strobe widths from the package
`timescale 1ns/1ps
module fbl_cycle
  import fbl_pkg::*;
#(
  parameter int ADDR_W = 22
) (
  input  wire logic              clk,
  input  wire logic              reset,
  fbl_cyc_if.eng                 cyc,
  output logic [ADDR_W-1:0]      flash_addr,
  output logic [15:0]            flash_dq_o,
  output logic                   flash_dq_oe_n,
  output logic                   flash_ce_n,
  output logic                   flash_we_n,
  output logic                   flash_oe_n,
  input  wire logic [15:0]       flash_dq_i
);

  typedef enum logic [1:0] {
    C_IDLE  = 2'b00,
    C_SETUP = 2'b01,
    C_PULSE = 2'b10,
    C_HOLD  = 2'b11
  } fbl_cyc_e;

  typedef struct packed {
    fbl_cyc_e          st;
    logic [3:0]        cnt;
    logic [ADDR_W-1:0] addr;
    logic [15:0]       dout;
    logic              dq_oe_n;
    logic              ce_n;
    logic              we_n;
    logic              oe_n;
    logic              wr;
    logic [15:0]       rdata;
    logic              done;
    logic [15:0]       sync1;
    logic [15:0]       sync2;
  } fbl_cyc_s;

  localparam fbl_cyc_s CYC_RST = '{st: C_IDLE, cnt: 4'h0, addr: '0, dout: 16'h0000,
                                   dq_oe_n: 1'b1, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                                   wr: 1'b0, rdata: 16'h0000, done: 1'b0,
                                   sync1: 16'h0000, sync2: 16'h0000};

  fbl_cyc_s r;
  fbl_cyc_s n;

  always_comb begin
    n       = r;
    n.done  = 1'b0;
    n.sync1 = flash_dq_i;
    n.sync2 = r.sync1;
    case (r.st)
      C_IDLE: begin
        if (cyc.req) begin
          n.addr    = cyc.addr;
          n.dout    = cyc.wdata;
          n.wr      = cyc.wr;
          n.ce_n    = 1'b0;
          n.dq_oe_n = !cyc.wr;
          n.st      = C_SETUP;
        end
      end
      C_SETUP: begin
        n.we_n = !r.wr;
        n.oe_n = r.wr;
        n.cnt  = r.wr ? WP_CYC : RD_CYC;
        n.st   = C_PULSE;
      end
      C_PULSE: begin
        if (r.cnt == CNT_ONE) begin
          // Write data stays driven past the rising strobe for hold time
          n.we_n = 1'b1;
          n.oe_n = 1'b1;
          if (!r.wr) begin
            n.rdata = r.sync2;
          end
          n.st = C_HOLD;
        end else begin
          n.cnt = r.cnt - CNT_ONE;
        end
      end
      C_HOLD: begin
        n.ce_n    = 1'b1;
        n.dq_oe_n = 1'b1;
        n.done    = 1'b1;
        n.st      = C_IDLE;
      end
      default: n = CYC_RST;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r <= CYC_RST;
    end else begin
      r <= n;
    end
  end

  assign flash_addr    = r.addr;
  assign flash_dq_o    = r.dout;
  assign flash_dq_oe_n = r.dq_oe_n;
  assign flash_ce_n    = r.ce_n;
  assign flash_we_n    = r.we_n;
  assign flash_oe_n    = r.oe_n;
  assign cyc.done      = r.done;
  assign cyc.rdata     = r.rdata;

endmodule // fbl_cycle

// [rtl/fbl_host.sv]
// Purpose: APB-driven host that locks, unlocks and queries flash blocks
// Assumes: Software orders one operation at a time and polls busy
// Notes:   Erase suspend polling is left to software via status reads
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
module fbl_host
  import fbl_pkg::*;
#(
  parameter int ADDR_W = 22
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic [ADDR_W-1:0]      flash_addr,
  output logic [15:0]            flash_dq_o,
  output logic                   flash_dq_oe_n,
  input  wire logic [15:0]       flash_dq_i,
  output logic                   flash_ce_n,
  output logic                   flash_we_n,
  output logic                   flash_oe_n,
  output logic                   flash_wp_n,
  output logic                   flash_rst_n
);

  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_ISSUE = 2'b01,
    S_WAIT  = 2'b10
  } fbl_seq_e;

  typedef struct packed {
    fbl_seq_e          st;
    fbl_op_e           op;
    logic [1:0]        step;
    logic [ADDR_W-1:0] blk;
    logic [15:0]       rdata;
    logic              refused;
    logic              wp_n;
    logic              rst_n;
    logic              req;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [15:0]       wdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
  } fbl_top_s;

  localparam fbl_top_s TOP_RST = '{st: S_IDLE, op: OP_NONE, step: 2'h0, blk: '0,
                                   rdata: 16'h0000, refused: 1'b0, wp_n: PIN_WP_RST,
                                   rst_n: PIN_RST_RST, req: 1'b0, wr: 1'b0, addr: '0,
                                   wdata: 16'h0000, prdata: 32'h0000_0000,
                                   pready: 1'b0, pslverr: 1'b0};

  fbl_top_s  r;
  fbl_top_s  n;
  fbl_step_s stp;
  logic      busy;
  logic      apb_setup;
  logic      apb_done;

  fbl_cyc_if #(.ADDR_W(ADDR_W)) cyc_bus ();

  assign busy      = (r.st != S_IDLE);
  assign apb_setup = psel && penable && !r.pready;
  assign apb_done  = psel && penable && r.pready;
  assign stp       = fbl_step(r.op, r.step);

  always_comb begin
    logic [31:0] status_v;
    status_v                      = 32'h0000_0000;
    status_v[ST_BUSY_BIT]         = busy;
    status_v[ST_REFUSED_BIT]      = r.refused;
    status_v[ST_DATA_LSB +: 16]   = r.rdata;
    n         = r;
    n.req     = 1'b0;
    n.pready  = 1'b0;
    n.pslverr = 1'b0;
    // Answer one cycle into the access phase so outputs come from flops
    if (apb_setup) begin
      n.pready = 1'b1;
      case (paddr)
        REG_CMD: begin
          n.prdata  = {29'h0, r.op};
          n.pslverr = pwrite && (busy || pwdata[2:0] == OP_NONE);
        end
        REG_ADDR:   n.prdata = {{(32 - ADDR_W){1'b0}}, r.blk};
        REG_STATUS: n.prdata = status_v;
        REG_PINCTL: n.prdata = {30'h0, r.rst_n, r.wp_n};
        default: begin
          n.prdata  = 32'h0000_0000;
          n.pslverr = 1'b1;
        end
      endcase
    end
    if (apb_done && pwrite && !r.pslverr) begin
      case (paddr)
        REG_CMD: begin
          n.op      = fbl_op_e'(pwdata[2:0]);
          n.step    = 2'h0;
          n.refused = 1'b0;
          n.st      = S_ISSUE;
        end
        REG_ADDR: n.blk = pwdata[ADDR_W-1:0];
        REG_PINCTL: begin
          n.wp_n  = pwdata[PIN_WP_BIT];
          n.rst_n = pwdata[PIN_RST_BIT];
        end
        default: n.blk = r.blk;
      endcase
    end
    // A refused order leaves the running sequence untouched
    if (apb_done && pwrite && r.pslverr && paddr == REG_CMD) begin
      n.refused = 1'b1;
    end
    case (r.st)
      S_IDLE: n.st = n.st;
      S_ISSUE: begin
        n.req   = 1'b1;
        n.wr    = stp.wr;
        n.addr  = stp.use_ofs ? r.blk + ADDR_W'(LOCK_STATUS_OFS) : r.blk;
        n.wdata = {8'h00, stp.code};
        n.st    = S_WAIT;
      end
      S_WAIT: begin
        if (cyc_bus.done) begin
          if (!r.wr) begin
            n.rdata = cyc_bus.rdata;
          end
          if (stp.last) begin
            n.st = S_IDLE;
          end else begin
            n.step = r.step + 2'h1;
            n.st   = S_ISSUE;
          end
        end
      end
      default: n.st = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r <= TOP_RST;
    end else begin
      r <= n;
    end
  end

  assign cyc_bus.req   = r.req;
  assign cyc_bus.wr    = r.wr;
  assign cyc_bus.addr  = r.addr;
  assign cyc_bus.wdata = r.wdata;

  fbl_cycle #(.ADDR_W(ADDR_W)) u_cycle (
    .clk           (clk),
    .reset         (reset),
    .cyc           (cyc_bus.eng),
    .flash_addr    (flash_addr),
    .flash_dq_o    (flash_dq_o),
    .flash_dq_oe_n (flash_dq_oe_n),
    .flash_ce_n    (flash_ce_n),
    .flash_we_n    (flash_we_n),
    .flash_oe_n    (flash_oe_n),
    .flash_dq_i    (flash_dq_i)
  );

  assign prdata      = r.prdata;
  assign pready      = r.pready;
  assign pslverr     = r.pslverr;
  assign flash_wp_n  = r.wp_n;
  assign flash_rst_n = r.rst_n;

  sequence s_setup_write;
    r.req && r.wr && r.wdata[7:0] == CMD_CFG_SETUP && r.addr == r.blk;
  endsequence

  sequence s_second_write(logic [7:0] code);
    r.req && r.wr && r.wdata[7:0] == code && r.addr == r.blk;
  endsequence

  property p_pair(fbl_op_e op_k, logic [7:0] code);
    @(posedge clk) disable iff (reset)
      (s_setup_write ##0 (r.op == op_k)) |-> ##[4:20] s_second_write(code);
  endproperty

  chk_lock_pair:     assert property (p_pair(OP_LOCK, CMD_LOCK))
    else $error("lock code did not follow setup");
  chk_unlock_pair:   assert property (p_pair(OP_UNLOCK, CMD_UNLOCK))
    else $error("unlock code did not follow setup");
  chk_lockdown_pair: assert property (p_pair(OP_LOCKDOWN, CMD_LOCKDOWN))
    else $error("lock-down code did not follow setup");

  chk_cfg_read_addr: assert property (@(posedge clk) disable iff (reset)
    (r.req && r.wdata[7:0] == CMD_CFG_READ && r.op == OP_READ_LOCK)
      |-> ##[4:20] (r.req && !r.wr && r.addr == r.blk + ADDR_W'(LOCK_STATUS_OFS)))
    else $error("lock status read not at block plus two");

  chk_read_capture: assert property (@(posedge clk) disable iff (reset)
    (r.st == S_WAIT && cyc_bus.done && !r.wr) |=> (r.rdata == $past(cyc_bus.rdata)))
    else $error("lock status word not captured");

  chk_suspend_code: assert property (@(posedge clk) disable iff (reset)
    (r.req && (r.op == OP_SUSPEND || r.op == OP_RESUME))
      |-> (r.wr && r.wdata[7:0] == (r.op == OP_SUSPEND ? CMD_SUSPEND : CMD_RESUME)))
    else $error("suspend or resume code wrong");

  chk_wp_held: assert property (@(posedge clk) disable iff (reset)
    $changed(r.wp_n) |-> $past(apb_done && pwrite && paddr == REG_PINCTL))
    else $error("write-protect moved without software order");

  chk_busy_refuse: assert property (@(posedge clk) disable iff (reset)
    (apb_setup && pwrite && paddr == REG_CMD && busy) |=> (r.pslverr && r.pready))
    else $error("order while busy not refused");

endmodule // fbl_host

// [testbench/fbl_flash_model.sv]
// Purpose: Behavioural flash device with block locks, status and config read
// Assumes: 32-Kword blocks picked by the top seven address bits
// Notes:   Commands latch on the rising write strobe; no program suspend
`timescale 1ns/1ps
module fbl_flash_model #(
  parameter int ADDR_W = 22
) (
  input  wire logic [ADDR_W-1:0] flash_addr,
  input  wire logic [15:0]       flash_dq_o,
  input  wire logic              flash_dq_oe_n,
  input  wire logic              flash_ce_n,
  input  wire logic              flash_we_n,
  input  wire logic              flash_oe_n,
  input  wire logic              flash_wp_n,
  input  wire logic              flash_rst_n,
  output logic [15:0]            flash_dq_i
);
  bit   [127:0] lk = '1;
  bit   [127:0] ld = '0;
  bit   [7:0]   sr = 8'h80;
  bit   [1:0]   mode = 2'h0;
  bit           setup = 1'b0;
  bit           wp_q = 1'b0;
  logic [15:0]  rd_val;
  logic [15:0]  rd_last = 16'h0000;
  logic [6:0]   b;
  logic [7:0]   c;
  assign b = flash_addr[ADDR_W-1 -: 7];
  assign c = flash_dq_o[7:0];

  always @(posedge flash_we_n or negedge flash_rst_n or flash_wp_n) begin
    if (!flash_rst_n) begin
      lk = '1;
      ld = '0;
      sr = 8'h80;
      mode = 2'h0;
      setup = 1'b0;
    end else if (wp_q != flash_wp_n) begin
      wp_q = flash_wp_n;
      if (!flash_wp_n) lk = lk | ld;
    end else if (!flash_ce_n) begin
      if (setup) begin
        setup = 1'b0;
        mode = 2'h1;
        if (c == 8'h2F) begin
          ld[b] = 1'b1;
          lk[b] = 1'b1;
        end else if ((c == 8'h01 || c == 8'hD0) && !(ld[b] && !flash_wp_n))
          lk[b] = (c == 8'h01);
        else if (c != 8'h01 && c != 8'hD0) sr[5:4] = 2'h3;
      end else begin
        case (c)
          8'h60: setup = !sr[2];
          8'h90: mode = 2'h2;
          8'h70: mode = 2'h1;
          8'hB0: begin
            sr[6] = 1'b1;
            mode = 2'h1;
          end
          8'hD0: begin
            sr[6] = 1'b0;
            mode = 2'h0;
          end
          8'h40, 8'h20: begin
            if (lk[b]) sr[1] = 1'b1;
            mode = 2'h1;
          end
          default: mode = 2'h0;
        endcase
      end
    end
  end

  always_comb begin
    rd_val = {8'h00, sr};
    if (mode == 2'h2) rd_val = (flash_addr[14:0] == 15'h0002) ? {14'h0, ld[b], lk[b]} : 16'h0;
    else if (mode == 2'h0) rd_val = 16'hFFFF;
  end

  always @(posedge flash_oe_n) rd_last <= rd_val;
  // A released bus shows the inverse of the last word, never a held copy
  assign flash_dq_i = !flash_dq_oe_n ? flash_dq_o
                    : (!flash_ce_n && !flash_oe_n) ? rd_val : ~rd_last;
endmodule // fbl_flash_model

// [testbench/testbench.sv]
// Purpose: Self-checking bench for the flash block-lock host
// Assumes: Flash model on the pins; APB master tasks
// Notes:   Tests are sequences of register calls with expected values
`timescale 1ns/1ps
module testbench;
  import fbl_pkg::*;
  logic              clk = 1'b0;
  logic              reset = 1'b1;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0]       pwdata = '0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [21:0]       flash_addr;
  logic [15:0]       flash_dq_o;
  logic [15:0]       flash_dq_i;
  logic              flash_dq_oe_n;
  logic              flash_ce_n;
  logic              flash_we_n;
  logic              flash_oe_n;
  logic              flash_wp_n;
  logic              flash_rst_n;
  int                error_cnt = 0;
  int                num_checks = 0;
  logic [31:0]       rd;
  logic              err;

  always #20 clk = ~clk;

  fbl_host dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_addr(flash_addr), .flash_dq_o(flash_dq_o), .flash_dq_oe_n(flash_dq_oe_n),
    .flash_dq_i(flash_dq_i), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n), .flash_wp_n(flash_wp_n), .flash_rst_n(flash_rst_n));

  fbl_flash_model flash (.flash_addr(flash_addr), .flash_dq_o(flash_dq_o),
    .flash_dq_oe_n(flash_dq_oe_n), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n), .flash_wp_n(flash_wp_n), .flash_rst_n(flash_rst_n),
    .flash_dq_i(flash_dq_i));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Entered just after a rising edge; leaves one idle edge before returning
  // No local limit: only the watchdog ends a wait for the slave
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_idle();
    do begin
      apb(1'b0, REG_STATUS, 32'h0);
    end while (rd[ST_BUSY_BIT] !== 1'b0);
  endtask

  task automatic op(input logic [2:0] o, input logic [6:0] blk);
    apb(1'b1, REG_ADDR, {10'h000, blk, 15'h0000});
    apb(1'b1, REG_CMD, {29'h0, o});
    wait_idle();
  endtask

  task automatic chk_lock(input logic [6:0] blk, input logic [1:0] exp);
    op(3'h4, blk);
    check({30'h0, rd[ST_DATA_LSB +: 2]}, {30'h0, exp});
  endtask

  task automatic step(input logic [2:0] o, input logic [6:0] blk, input logic [1:0] exp);
    op(o, blk);
    chk_lock(blk, exp);
  endtask

  task automatic chk_sr(input logic [7:0] exp);
    op(3'h7, 7'h00);
    check({24'h0, rd[ST_DATA_LSB +: 8]}, {24'h0, exp});
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_sim();
  end

  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check({30'h0, flash_rst_n, flash_wp_n}, 32'h2);
    apb(1'b0, REG_PINCTL, 32'h0);
    check(rd, 32'h2);
    apb(1'b0, 8'h10, 32'h0);
    check({rd[30:0], err}, 32'h1);
    apb(1'b1, REG_CMD, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b0, REG_STATUS, 32'h0);
    check({31'h0, rd[ST_REFUSED_BIT]}, 32'h1);
    chk_lock(7'h00, 2'b01);
    chk_lock(7'h7F, 2'b01);
    $display("test reset done");
    step(3'h2, 7'h01, 2'b00);
    step(3'h1, 7'h01, 2'b01);
    step(3'h2, 7'h01, 2'b00);
    step(3'h3, 7'h01, 2'b11);
    step(3'h2, 7'h01, 2'b11);
    step(3'h1, 7'h01, 2'b11);
    chk_lock(7'h02, 2'b01);
    chk_sr(8'h80);
    apb(1'b1, REG_ADDR, {10'h000, 7'h02, 15'h0000});
    apb(1'b1, REG_CMD, 32'h2);
    apb(1'b1, REG_CMD, 32'h1);
    check({31'h0, err}, 32'h1);
    wait_idle();
    check({31'h0, rd[ST_REFUSED_BIT]}, 32'h1);
    apb(1'b0, REG_CMD, 32'h0);
    check(rd, 32'h2);
    apb(1'b0, REG_ADDR, 32'h0);
    check(rd, {10'h000, 7'h02, 15'h0000});
    chk_lock(7'h02, 2'b00);
    $display("test software locks done");
    apb(1'b1, REG_PINCTL, 32'h3);
    step(3'h2, 7'h01, 2'b10);
    step(3'h1, 7'h01, 2'b11);
    step(3'h2, 7'h01, 2'b10);
    step(3'h3, 7'h02, 2'b11);
    step(3'h1, 7'h03, 2'b01);
    apb(1'b1, REG_PINCTL, 32'h2);
    chk_lock(7'h01, 2'b11);
    chk_lock(7'h02, 2'b11);
    $display("test write protect done");
    op(3'h5, 7'h04);
    chk_sr(8'hC0);
    step(3'h3, 7'h04, 2'b11);
    op(3'h6, 7'h04);
    chk_sr(8'h80);
    $display("test erase suspend done");
    step(3'h2, 7'h00, 2'b00);
    apb(1'b1, REG_PINCTL, 32'h0);
    check({31'h0, flash_rst_n}, 32'h0);
    apb(1'b1, REG_PINCTL, 32'h2);
    chk_lock(7'h00, 2'b01);
    chk_lock(7'h01, 2'b01);
    chk_lock(7'h04, 2'b01);
    $display("test device reset done");
    end_sim();
  end
endmodule // testbench
